// ---- bench/dpd_channel_tb_top.sv ----
`timescale 1ns/100ps
module dpd_channel_tb_top;
  import dpd_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sel = 1'b0;
  logic        we = 1'b0;
  logic        ev = 1'b0;
  logic        hold = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata, xs, xd;
  logic        rvalid, xv, xr, xps, xpd, busy, done, alt, cerr;
  logic [1:0]  xw, e_w;
  logic [2:0]  xu, e_u;
  logic [5:0]  dcode, acode;
  logic        e_ps, e_pd;
  logic [31:0] qs[$];
  logic [31:0] qd[$];
  logic [31:0] o;
  int          fail_count = 0;
  int          n_compared = 0;
  int          n_done, n_alt, n_err, it, fr;

  always #50 clk = ~clk;

  dpd_channel i_dut (
    .MCLK_I(clk), .SYS_RST_I(rst), .PB_SEL_I(sel), .PB_WE_I(we), .PB_ADDR_I(addr),
    .PB_WDATA_I(wdata), .PB_RDATA_O(rdata), .PB_RVALID_O(rvalid), .EVENT_I(ev),
    .XFER_VALID_O(xv), .XFER_READY_I(xr), .XFER_SRC_O(xs), .XFER_DST_O(xd),
    .XFER_WIDTH_O(xw), .XFER_URGENCY_O(xu), .XFER_PDT_SRC_O(xps), .XFER_PDT_DST_O(xpd),
    .BUSY_O(busy), .DONE_O(done), .DONE_CODE_O(dcode), .ALT_O(alt), .ALT_CODE_O(acode),
    .CFG_ERR_O(cerr)
  );

  dpd_sink i_sink (.clk_i(clk), .rst_i(rst), .hold_i(hold), .ready_o(xr));

  // -------------------------------------------------
  // Compare, bus and closing tasks
  // -------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic close_out;
    if (fail_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    #1 sel = 1'b1;
    we = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1 sel = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge clk);
    #1 sel = 1'b1;
    we = 1'b0;
    addr = a;
    @(posedge clk);
    #1 sel = 1'b0;
    chk(rvalid, 1'b1);
    chk(rdata, e);
  endtask

  // Address step of one element, expectation side
  function automatic logic [31:0] nxt(input logic [1:0] m, input logic [31:0] a,
                                      input logic [1:0] w, input bit last,
                                      input logic [15:0] ei, input logic [15:0] fi);
    logic [31:0] sz;
    sz = (w == WID_WORD) ? 32'h4 : (w == WID_HALF) ? 32'h2 : 32'h1;
    case (m)
      UPD_FIXED: return a;
      UPD_INC:   return a + sz;
      UPD_DEC:   return a - sz;
      default:   return a + {{16{last ? fi[15] : ei[15]}}, last ? fi : ei};
    endcase
  endfunction

  // -------------------------------------------------
  // Stream and flag monitor
  // -------------------------------------------------
  always @(posedge clk)
  begin
    if (xv === 1'b1 && xr === 1'b1)
    begin
      qs.push_back(xs);
      qd.push_back(xd);
      chk({xu, xw}, {e_u, e_w});
      chk({xps, xpd}, {e_ps, e_pd});
    end
    if (done === 1'b1)
      n_done++;
    if (alt === 1'b1)
      n_alt++;
    if (cerr === 1'b1)
      n_err++;
  end

  task automatic run(input logic [31:0] op, input logic [15:0] items, input logic [15:0] frames,
                     input logic [15:0] ei, input logic [15:0] fi, input int nev);
    logic [31:0] s, d, es, ed;
    bit          ok, good, last;
    int          k;
    s = $urandom;
    d = $urandom;
    good = op[28:27] != WID_RSVD && !op[31];
    ok = good && items != 16'h0000;
    wr(16'h0000, op);
    wr(16'h0004, s);
    wr(16'h0008, {frames, items});
    wr(16'h000c, d);
    wr(16'h0010, {fi, ei});
    wr(16'h0014, {items, 16'h0600});
    qs.delete();
    qd.delete();
    n_done = 0;
    n_alt = 0;
    n_err = 0;
    e_u = op[31:29];
    e_w = op[28:27];
    e_ps = op[3];
    e_pd = op[2];
    repeat (nev)
    begin
      @(posedge clk);
      #1 ev = 1'b1;
      @(posedge clk);
      #1 ev = 1'b0;
      k = 0;
      repeat (3) @(posedge clk);
      #1;
      while ((busy !== 1'b0 || xv !== 1'b0) && k < 2000)
      begin
        @(posedge clk);
        #1 k++;
      end
      if (k == 2000)
        chk({busy, xv}, 2'b00);
    end
    repeat (3) @(posedge clk);
    chk(qs.size(), ok ? int'(items) * (int'(frames) + 1) : 0);
    chk(n_err, !good);
    chk(n_done, ok && op[20]);
    if (ok && op[20])
      chk(dcode, {op[14:13], op[19:16]});
    chk(n_alt, (ok && op[12]) ? nev - 1 : 0);
    if (ok && op[12])
      chk(acode, op[10:5]);
    es = s;
    ed = d;
    for (int i = 0; i < qs.size(); i++)
    begin
      last = ((i + 1) % int'(items)) == 0;
      chk(qs[i], es);
      chk(qd[i], ed);
      es = nxt(op[25:24], es, op[28:27], last, ei, fi);
      ed = nxt(op[22:21], ed, op[28:27], last, ei, fi);
    end
  endtask

  // -------------------------------------------------
  // Main sequence and watchdog
  // -------------------------------------------------
  initial
  begin
    #2_000_000;
    fail_count++;
    close_out();
  end

  initial
  begin
    void'($urandom(96));
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    chk({xv, busy, done, alt, cerr}, 5'h00);
    wr(16'h0004, 32'ha5a5_5a5a);
    wr(16'h0804, 32'h1234_5678);
    rd(16'h0004, 32'ha5a5_5a5a);
    rd(16'h0804, 32'h0000_0000);
    wr(16'h0014, 32'h0003_0600);
    rd(16'h0014, 32'h0003_0600);
    // Receiver held: buffer must fill and keep every word
    hold = 1'b1;
    fork
      run(32'h2155_0001, 16'h0004, 16'h0000, 16'h0000, 16'h0000, 1);
      begin
        repeat (40) @(posedge clk);
        #1 chk(xv, 1'b1);
        hold = 1'b0;
      end
    join
    run(32'h2010_0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 1);
    run(32'h3810_0001, 16'h0002, 16'h0000, 16'h0000, 16'h0000, 1);
    run(32'h8010_0001, 16'h0002, 16'h0000, 16'h0000, 16'h0000, 1);
    // Two-dimensional arrays, one array per event
    run(32'h25b1_1000, 16'h0003, 16'h0001, 16'h0000, 16'h0000, 2);
    // Reload set in the reload area must land in the channel entry
    for (int i = 0; i < 6; i++)
      wr(16'(16'h0600 + 4 * i), 32'hc0de_0000 + 32'(i));
    run(32'h2010_0003, 16'h0002, 16'h0000, 16'h0000, 16'h0000, 1);
    for (int i = 0; i < 6; i++)
      rd(16'(4 * i), 32'hc0de_0000 + 32'(i));
    for (int n = 0; n < 10; n++)
    begin
      o = $urandom;
      o[31:29] = 3'($urandom % 4);
      o[28:27] = 2'($urandom % 3);
      o[26] = 1'b0;
      o[23] = 1'b0;
      o[1] = 1'b0;
      it = 1 + $urandom % 3;
      fr = $urandom % 3;
      run(o, 16'(it), 16'(fr), 16'($urandom), 16'($urandom), o[0] ? fr + 1 : it * (fr + 1));
    end
    close_out();
  end
endmodule

// ---- bench/dpd_sink.sv ----
`timescale 1ns/100ps
module dpd_sink (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Stall control and stream handshake
  input  wire logic hold_i,
  output logic      ready_o
);
  // -------------------------------------------------
  // Receiver: random stalls, long stall while held
  // -------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ready_o <= 1'b0;
    else
      ready_o <= !hold_i && ($urandom % 3 != 0);
  end
endmodule

// ---- rtl/dpd_buf.sv ----
`timescale 1ns/100ps
module dpd_buf
  import dpd_pkg::*;
#(
  parameter int W     = 71,
  parameter int DEPTH = 2
)(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Filling side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Draining side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("dpd_buf depth must be a power of two, at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0]   fill;
  logic          push;
  logic          pop;

  // No path from the drain side; a full buffer waits one pop
  assign in_ready_o  = (fill != (PW+1)'(DEPTH));
  assign out_valid_o = (fill != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr] <= in_data_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      fill <= fill + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule

// ---- rtl/dpd_channel.sv ----
`timescale 1ns/100ps
// Function
// (RULE1) Urgency field selects request priority
// (RULE2) Element width: word, half, byte, reserved
// (RULE3) Bit 26 picks one or two dimensional source
// (RULE4) Source address fixed, up, down, or indexed
// (RULE5) Bit 23 picks one or two dimensional destination
// (RULE6) Destination address fixed, up, down, or indexed
// (RULE7) Completion flag only when enable bit set
// (RULE8) Four-bit code names the completion flag
// (RULE9) Larger variant adds two upper code bits
// (RULE10) Alternate flag after each intermediate chunk
// (RULE11) Peripheral direct read and write enables
// (RULE12) Reload entry from pointer after exhaustion
// (RULE13) Bit 0: element or whole frame per event
// (RULE14) Element count 1..65535, zero moves nothing
// (RULE15) Frame count stores frames minus one
// (RULE16) Indexes are signed sixteen-bit offsets
// (RULE17) Item stride only in one-dimensional transfers
// (RULE18) One-dimensional element sync restores count per frame
// (RULE19) Pointer gives only low sixteen address bits
// (RULE20) Software keeps pointers on 24-byte boundaries
// (RULE21) Reload sets anywhere in setting memory
// (RULE22) Shared words accessed only as whole words
// (RULE23) Six words: options, source, counts, destination, strides, reload
// (RULE24) Reserved urgency or width starts no movement
module dpd_channel
  import dpd_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter int CHANNEL       = 0,
  parameter int BUF_DEPTH     = 2
)(
  // Clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        SYS_RST_I,
  // Peripheral bus into setting memory
  input  wire logic        PB_SEL_I,
  input  wire logic        PB_WE_I,
  input  wire logic [15:0] PB_ADDR_I,
  input  wire logic [31:0] PB_WDATA_I,
  output logic [31:0]      PB_RDATA_O,
  output logic             PB_RVALID_O,
  // Channel event
  input  wire logic        EVENT_I,
  // Element request stream
  output logic             XFER_VALID_O,
  input  wire logic        XFER_READY_I,
  output logic [31:0]      XFER_SRC_O,
  output logic [31:0]      XFER_DST_O,
  output logic [1:0]       XFER_WIDTH_O,
  output logic [2:0]       XFER_URGENCY_O,
  output logic             XFER_PDT_SRC_O,
  output logic             XFER_PDT_DST_O,
  // Status
  output logic             BUSY_O,
  output logic             DONE_O,
  output logic [5:0]       DONE_CODE_O,
  output logic             ALT_O,
  output logic [5:0]       ALT_CODE_O,
  output logic             CFG_ERR_O
);

  initial
  begin
    if (CHANNEL < 0 || (CHANNEL + 1) * ENTRY_WORDS > MEM_WORDS)
      $error("dpd_channel entry does not fit setting memory");
  end

  localparam logic [8:0] CHAN_BASE = 9'(CHANNEL * ENTRY_WORDS);
  localparam int         BW        = 71;

  // ----------------------------------------------------------------
  // Setting memory
  // ----------------------------------------------------------------
  logic [31:0] mem [MEM_WORDS];
  dpd_state_t  state;
  logic [2:0]  k;
  logic [15:0] ptr;
  logic [8:0]  bus_word;
  logic        bus_hit;
  logic [8:0]  link_base;

  // Low two bits ignored: only whole words are accessed
  assign bus_word  = PB_ADDR_I[10:2]; // RULE22
  assign bus_hit   = PB_SEL_I && (PB_ADDR_I[15:11] == 5'h00);
  // Pointer holds low address bits only; region is implied
  assign link_base = ptr[10:2]; // RULE19

  always_ff @(posedge MCLK_I)
  begin
    // Any entry, spare channel or reload area, may be a source
    if (state == ST_LINK)
      mem[CHAN_BASE + 9'(k)] <= mem[link_base + 9'(k)]; // RULE12 RULE21
    if (bus_hit && PB_WE_I)
      mem[bus_word] <= PB_WDATA_I;
  end

  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
    begin
      PB_RDATA_O  <= WORD_RESET;
      PB_RVALID_O <= 1'b0;
    end
    else
    begin
      PB_RVALID_O <= PB_SEL_I && !PB_WE_I;
      PB_RDATA_O  <= (PB_SEL_I && !PB_WE_I && bus_hit) ? mem[bus_word] : WORD_RESET;
    end
  end

  // ----------------------------------------------------------------
  // Working copy of the entry
  // ----------------------------------------------------------------
  logic [31:0] channel_options_word;
  logic [31:0] src_cur;
  logic [31:0] src_row;
  logic [31:0] dst_cur;
  logic [31:0] dst_row;
  logic [15:0] cnt;
  logic [15:0] cnt_init;
  logic [15:0] fcnt;
  logic [15:0] eidx;
  logic [15:0] fidx;
  logic [15:0] rld;
  logic        loaded;
  logic        pend;
  logic [31:0] rd_word;

  assign rd_word = mem[CHAN_BASE + 9'(k)];

  wire [2:0] urg      = channel_options_word[OPT_URG_HI:OPT_URG_LO];
  wire [1:0] wid      = channel_options_word[OPT_WID_HI:OPT_WID_LO];
  wire       src_2d   = channel_options_word[OPT_SRC_2D]; // RULE3
  wire       dst_2d   = channel_options_word[OPT_DST_2D]; // RULE5
  wire [1:0] sum_mode = channel_options_word[OPT_SUM_HI:OPT_SUM_LO];
  wire [1:0] dum_mode = channel_options_word[OPT_DUM_HI:OPT_DUM_LO];
  wire       fs       = channel_options_word[OPT_FSYNC];
  wire       any_2d   = src_2d || dst_2d;

  // Reserved urgency codes depend on the variant
  logic urg_bad;
  logic cfg_bad;
  always_comb
  begin
    urg_bad = urg[2]; // RULE1
    if (!LARGE_VARIANT && (urg == URG_URGENT || urg == URG_LOW))
      urg_bad = 1'b1; // RULE1
    cfg_bad = urg_bad || (wid == WID_RSVD); // RULE2 RULE24
  end

  logic [31:0] elem_bytes;
  always_comb
  begin
    case (wid)
      WID_WORD: elem_bytes = 32'h0000_0004; // RULE2
      WID_HALF: elem_bytes = 32'h0000_0002;
      WID_BYTE: elem_bytes = 32'h0000_0001;
      default:  elem_bytes = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Address stepping
  // ----------------------------------------------------------------
  function automatic logic [31:0] step_addr(
    input logic [1:0]  mode,
    input logic        two_d,
    input logic        frame_end,
    input logic [31:0] cur,
    input logic [31:0] row,
    input logic [31:0] sz,
    input logic [15:0] ei,
    input logic [15:0] fi
  );
    logic [31:0] e;
    logic [31:0] f;
    e = {{16{ei[15]}}, ei}; // RULE16
    f = {{16{fi[15]}}, fi}; // RULE16
    case (mode)
      UPD_FIXED: step_addr = cur;
      UPD_INC:   step_addr = cur + sz;
      UPD_DEC:   step_addr = cur - sz;
      UPD_INDEX:
      begin
        // Arrays are contiguous; stride only moves the array start
        if (two_d)
          step_addr = frame_end ? row + f : cur + sz; // RULE17
        else
          step_addr = frame_end ? cur + f : cur + e; // RULE17
      end
      default:   step_addr = cur;
    endcase
  endfunction

  logic [31:0] next_src;
  logic [31:0] next_dst;
  logic        last_elem;
  logic        block_end;
  logic        chunk_end;

  assign last_elem = (cnt == 16'h0001);
  assign block_end = last_elem && (fcnt == 16'h0000); // RULE15
  // Element sync moves one element, or one array when 2D
  assign chunk_end = fs ? (any_2d ? block_end : last_elem)
                        : (any_2d ? last_elem : 1'b1); // RULE13
  assign next_src  = step_addr(sum_mode, src_2d, last_elem, src_cur, src_row,
                               elem_bytes, eidx, fidx); // RULE4
  assign next_dst  = step_addr(dum_mode, dst_2d, last_elem, dst_cur, dst_row,
                               elem_bytes, eidx, fidx); // RULE6

  // ----------------------------------------------------------------
  // Request buffer
  // ----------------------------------------------------------------
  logic          buf_ready;
  logic          push;
  logic [BW-1:0] buf_in;
  logic [BW-1:0] buf_out;

  assign push   = (state == ST_MOVE) && buf_ready;
  assign buf_in = {urg, wid, channel_options_word[OPT_PDT_SRC], channel_options_word[OPT_PDT_DST], src_cur, dst_cur}; // RULE11

  dpd_buf #(
    .W     (BW),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk_i       (MCLK_I),
    .rst_i       (SYS_RST_I),
    .in_valid_i  (state == ST_MOVE),
    .in_ready_o  (buf_ready),
    .in_data_i   (buf_in),
    .out_valid_o (XFER_VALID_O),
    .out_ready_i (XFER_READY_I),
    .out_data_o  (buf_out)
  );

  assign XFER_URGENCY_O = buf_out[70:68];
  assign XFER_WIDTH_O   = buf_out[67:66];
  assign XFER_PDT_SRC_O = LARGE_VARIANT ? buf_out[65] : 1'b0; // RULE11
  assign XFER_PDT_DST_O = LARGE_VARIANT ? buf_out[64] : 1'b0; // RULE11
  assign XFER_SRC_O     = buf_out[63:32];
  assign XFER_DST_O     = buf_out[31:0];
  assign BUSY_O         = (state != ST_IDLE);

  // ----------------------------------------------------------------
  // Event latch
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
      pend <= 1'b0;
    else if (EVENT_I)
      pend <= 1'b1;
    else if (state == ST_IDLE)
      pend <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
    begin
      state  <= ST_IDLE;
      k      <= 3'h0;
      loaded <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          k <= 3'h0;
          if (pend)
            state <= loaded ? ST_MOVE : ST_LOAD;
        end
        ST_LOAD:
        begin
          k <= k + 3'h1;
          if (k == W_RLD)
            state <= ST_CHECK;
        end
        ST_CHECK:
        begin
          k <= 3'h0;
          if (cfg_bad || cnt == 16'h0000)
            state <= ST_IDLE; // RULE14 RULE24
          else
          begin
            loaded <= 1'b1;
            state  <= ST_MOVE;
          end
        end
        ST_MOVE:
        begin
          if (push && chunk_end)
          begin
            if (block_end)
            begin
              loaded <= 1'b0;
              state  <= channel_options_word[OPT_RELOAD] ? ST_LINK : ST_IDLE; // RULE12
            end
            else
              state <= ST_IDLE;
          end
        end
        ST_LINK:
        begin
          k <= k + 3'h1;
          if (k == W_RLD)
            state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Entry words in fixed order; upper halves carry the second field
  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
    begin
      channel_options_word      <= WORD_RESET;
      cnt      <= 16'h0000;
      cnt_init <= 16'h0000;
      fcnt     <= 16'h0000;
      eidx     <= 16'h0000;
      fidx     <= 16'h0000;
      rld      <= 16'h0000;
      ptr      <= 16'h0000;
    end
    else if (state == ST_LOAD)
    begin
      case (k)
        W_OPT: channel_options_word <= rd_word; // RULE23
        W_CNT:
        begin
          cnt      <= rd_word[15:0]; // RULE23
          cnt_init <= rd_word[15:0];
          fcnt     <= rd_word[31:16];
        end
        W_IDX:
        begin
          eidx <= rd_word[15:0]; // RULE23
          fidx <= rd_word[31:16];
        end
        W_RLD:
        begin
          ptr <= rd_word[15:0]; // RULE23
          rld <= rd_word[31:16];
        end
        default: ;
      endcase
    end
    else if (push)
    begin
      if (!last_elem)
        cnt <= cnt - 16'h0001;
      else if (!block_end)
      begin
        fcnt <= fcnt - 16'h0001; // RULE15
        // 1D element sync tracks position through the restore value
        cnt  <= (!any_2d && !fs) ? rld : cnt_init; // RULE18
      end
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
    begin
      src_cur <= WORD_RESET;
      src_row <= WORD_RESET;
      dst_cur <= WORD_RESET;
      dst_row <= WORD_RESET;
    end
    else if (state == ST_LOAD && k == W_SRC)
    begin
      src_cur <= rd_word;
      src_row <= rd_word;
    end
    else if (state == ST_LOAD && k == W_DST)
    begin
      dst_cur <= rd_word;
      dst_row <= rd_word;
    end
    else if (push)
    begin
      src_cur <= next_src; // RULE4
      dst_cur <= next_dst; // RULE6
      if (last_elem)
      begin
        src_row <= next_src;
        dst_row <= next_dst;
      end
    end
  end

  // ----------------------------------------------------------------
  // Completion flags
  // ----------------------------------------------------------------
  wire [1:0] code_upper = LARGE_VARIANT ? channel_options_word[OPT_CODEU_HI:OPT_CODEU_LO] : 2'b00;

  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
    begin
      DONE_O      <= 1'b0;
      DONE_CODE_O <= 6'h00;
      ALT_O       <= 1'b0;
      ALT_CODE_O  <= 6'h00;
      CFG_ERR_O   <= 1'b0;
    end
    else
    begin
      DONE_O    <= push && block_end && channel_options_word[OPT_DONE_EN]; // RULE7
      ALT_O     <= push && chunk_end && !block_end && channel_options_word[OPT_ALT_EN]
                   && LARGE_VARIANT; // RULE10
      CFG_ERR_O <= (state == ST_CHECK) && cfg_bad; // RULE24
      if (push && block_end)
        DONE_CODE_O <= {code_upper, channel_options_word[OPT_CODE_HI:OPT_CODE_LO]}; // RULE8 RULE9
      if (push && chunk_end && !block_end)
        ALT_CODE_O <= channel_options_word[OPT_ALT_HI:OPT_ALT_LO]; // RULE10
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_block_last;
    push && block_end;
  endsequence

  sequence s_link_copy;
    (state == ST_LINK) [*6] ##1 (state == ST_IDLE);
  endsequence

  bad_cfg_stop_a: assert property ( // RULE24
    (state == ST_CHECK) && cfg_bad |=> CFG_ERR_O && (state == ST_IDLE) ##1 !push [*3])
    else $error("reserved setting started movement");

  zero_count_a: assert property ( // RULE14
    (state == ST_CHECK) && (cnt == 16'h0000) |=> (state == ST_IDLE) && !loaded)
    else $error("zero element count did not stop");

  width_legal_a: assert property ( // RULE2
    push |-> (buf_in[67:66] != WID_RSVD) && (elem_bytes != 32'h0))
    else $error("reserved element width pushed");

  done_flag_a: assert property ( // RULE7
    s_block_last |=> (DONE_O == $past(channel_options_word[OPT_DONE_EN]))
      && (DONE_CODE_O[3:0] == $past(channel_options_word[OPT_CODE_HI:OPT_CODE_LO])))
    else $error("completion flag mismatch");

  reload_copy_a: assert property ( // RULE12
    (s_block_last and channel_options_word[OPT_RELOAD]) |=> s_link_copy)
    else $error("reload did not copy six words");

  count_restore_a: assert property ( // RULE18
    push && last_elem && !block_end && !any_2d && !fs
      |=> (cnt == $past(rld)) && (fcnt == $past(fcnt) - 16'h0001))
    else $error("count not restored at frame end");

  elem_sync_a: assert property ( // RULE13
    push && !fs && !any_2d && !(block_end && channel_options_word[OPT_RELOAD]) |=> (state == ST_IDLE))
    else $error("element sync moved more than one element");

  fixed_src_a: assert property ( // RULE4
    push && (sum_mode == UPD_FIXED) |=> (src_cur == $past(src_cur)))
    else $error("fixed source address moved");

  stride_1d_a: assert property ( // RULE17
    push && !last_elem && !src_2d && (sum_mode == UPD_INDEX)
      |=> (src_cur == $past(src_cur) + {{16{$past(eidx[15])}}, $past(eidx)}))
    else $error("item stride not applied");

  alt_flag_a: assert property ( // RULE10
    ALT_O |-> LARGE_VARIANT && !DONE_O)
    else $error("alternate flag raised at block end");

endmodule

// ---- rtl/dpd_pkg.sv ----
package dpd_pkg;

  // ----------------------------------------------------------------
  // Options word field positions
  // ----------------------------------------------------------------
  localparam int OPT_URG_HI   = 31;
  localparam int OPT_URG_LO   = 29;
  localparam int OPT_WID_HI   = 28;
  localparam int OPT_WID_LO   = 27;
  localparam int OPT_SRC_2D   = 26;
  localparam int OPT_SUM_HI   = 25;
  localparam int OPT_SUM_LO   = 24;
  localparam int OPT_DST_2D   = 23;
  localparam int OPT_DUM_HI   = 22;
  localparam int OPT_DUM_LO   = 21;
  localparam int OPT_DONE_EN  = 20;
  localparam int OPT_CODE_HI  = 19;
  localparam int OPT_CODE_LO  = 16;
  localparam int OPT_CODEU_HI = 14;
  localparam int OPT_CODEU_LO = 13;
  localparam int OPT_ALT_EN   = 12;
  localparam int OPT_ALT_HI   = 10;
  localparam int OPT_ALT_LO   = 5;
  localparam int OPT_PDT_SRC  = 3;
  localparam int OPT_PDT_DST  = 2;
  localparam int OPT_RELOAD   = 1;
  localparam int OPT_FSYNC    = 0;

  // ----------------------------------------------------------------
  // Entry layout and memory map
  // ----------------------------------------------------------------
  localparam logic [2:0]  W_OPT   = 3'h0;
  localparam logic [2:0]  W_SRC   = 3'h1;
  localparam logic [2:0]  W_CNT   = 3'h2;
  localparam logic [2:0]  W_DST   = 3'h3;
  localparam logic [2:0]  W_IDX   = 3'h4;
  localparam logic [2:0]  W_RLD   = 3'h5;
  localparam logic [7:0]  OFS_NEXT_SET_PTR  = 8'h14;
  localparam logic [7:0]  OFS_COUNT_RESTORE = 8'h16;
  localparam int          ENTRY_WORDS  = 6;
  localparam int          MEM_WORDS    = 512;
  localparam int          MAX_ENTRIES  = 85;
  localparam logic [15:0] RELOAD_LO    = 16'h0600;
  localparam logic [15:0] RELOAD_HI    = 16'h07f7;
  localparam logic [31:0] WORD_RESET   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] URG_URGENT = 3'h0;
  localparam logic [2:0] URG_LOW    = 3'h3;
  localparam logic [1:0] WID_WORD   = 2'h0;
  localparam logic [1:0] WID_HALF   = 2'h1;
  localparam logic [1:0] WID_BYTE   = 2'h2;
  localparam logic [1:0] WID_RSVD   = 2'h3;
  localparam logic [1:0] UPD_FIXED  = 2'h0;
  localparam logic [1:0] UPD_INC    = 2'h1;
  localparam logic [1:0] UPD_DEC    = 2'h2;
  localparam logic [1:0] UPD_INDEX  = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_LOAD  = 3'h1,
    ST_CHECK = 3'h2,
    ST_MOVE  = 3'h3,
    ST_LINK  = 3'h4
  } dpd_state_t;

endpackage
